// file: include/master_port_regs.vh
// constants for the master port pin multiplexer and frame scheduler
`ifndef MASTER_PORT_REGS_VH
`define MASTER_PORT_REGS_VH

// one-hot master port modes
`define MODE_NONE 3'h0
`define MODE_PARALLEL 3'h1
`define MODE_I2C 3'h2
`define MODE_SPI 3'h4

// master port pin indices
`define PIN_ZERO 0
`define PIN_ONE 1
`define PIN_TWO 2
`define PIN_THREE 3

// synchroniser lane layout: master pins 0..3, general pins 4..6
`define LANE_GEN_BASE 4
`define SYNC_LANES 7

// sync input selection bits
`define SEL_HSYNC 0
`define SEL_VSYNC 1

// general pin indices
`define GEN_ONE 1
`define GEN_TWO 2

// frame scheduler defaults
`define SLOTS_PER_FRAME 16
`define SLOT_CYCLES 64
`define HOUSEKEEPING_SLOTS 2
`define SLOT_IDX_W 8
`define SLOT_CNT_W 16

`endif

// file: logic/master_port_pin_mux.v
// master port pin multiplexer, general pins, sync inputs and slot scheduler
`timescale 1ns/1ps
`default_nettype none
`include "master_port_regs.vh"

// Overview of operation
// RULE1: renderer runs the master port in one mode: parallel, i2c or spi
// RULE2: pin zero is parallel output one, i2c data, or spi data out
// RULE3: pin one is parallel output two, i2c clock, or spi clock out
// RULE4: pin two is parallel output three, interrupt input low, or spi data in
// RULE5: pin three is parallel output four, unused in i2c, or spi select low
// RULE6: an i2c peripheral signals interrupt by pulling the interrupt line low
// RULE7: peripherals sharing the interrupt report over i2c whether they assert it
// RULE8: three general pins with host-configured direction and use
// RULE9: when selected, general pin one is hsync and pin two vsync input
// RULE10: hardware reset low puts all logic into reset, no clock needed
// RULE11: with hardware reset high the block runs normally
// RULE12: each frame splits into slots, each with a measurement or housekeeping task
// RULE13: unused pins stay inactive; mode changes only when no transfer runs
module master_port_pin_mux #(
   parameter SLOTS_PER_FRAME = `SLOTS_PER_FRAME,
   parameter SLOT_CYCLES = `SLOT_CYCLES,
   parameter HOUSEKEEPING_SLOTS = `HOUSEKEEPING_SLOTS
) (
   // clock and hardware reset
   input wire clk_in,
   input wire nrst_in,
   // mode control from the renderer
   input wire [2:0] mode_req_in,
   input wire transfer_busy_in,
   output reg [2:0] mode_out,
   // renderer parallel outputs
   input wire [3:0] parallel_output_in,
   // renderer i2c master
   input wire master_i2c_data_drive_low_in,
   input wire master_i2c_clock_drive_low_in,
   output reg master_i2c_data_line_out,
   output reg master_i2c_clock_line_out,
   output reg master_interrupt_low_out,
   // renderer spi master
   input wire master_spi_data_out_in,
   input wire master_spi_clock_out_in,
   input wire master_spi_select_low_in,
   output reg master_spi_data_in_out,
   // master port pins
   input wire [3:0] master_pin_in,
   output reg [3:0] master_pin_out,
   output reg [3:0] master_pin_oe_out,
   // general pins
   input wire [2:0] general_pin_dir_in,
   input wire [2:0] general_pin_wr_in,
   input wire [1:0] sync_select_in,
   input wire [2:0] general_pin_in,
   output reg [2:0] general_pin_out,
   output reg [2:0] general_pin_oe_out,
   output reg [2:0] general_pin_rd_out,
   output reg hsync_out,
   output reg vsync_out,
   // frame scheduler
   input wire acq_enable_in,
   output reg frame_start_out,
   output reg [`SLOT_IDX_W-1:0] slot_index_out,
   output reg slot_housekeeping_out
);

   wire [`SYNC_LANES-1:0] pin_level;
   reg [2:0] next_mode;
   reg [3:0] next_pin_out;
   reg [3:0] next_pin_oe;
   reg [2:0] next_gen_oe;
   reg [`SLOT_CNT_W-1:0] slot_cycle;

   // end points worked out at integer width, then cut to the counter widths on purpose;
   // a frame longer than the index counter can hold would wrap silently
   localparam integer SLOT_LAST_FULL = SLOT_CYCLES - 1;
   localparam integer FRAME_LAST_FULL = SLOTS_PER_FRAME - 1;
   localparam integer HK_FIRST_FULL = SLOTS_PER_FRAME - HOUSEKEEPING_SLOTS;
   localparam [`SLOT_CNT_W-1:0] SLOT_LAST = SLOT_LAST_FULL[`SLOT_CNT_W-1:0];
   localparam [`SLOT_IDX_W-1:0] FRAME_LAST = FRAME_LAST_FULL[`SLOT_IDX_W-1:0];
   localparam [`SLOT_IDX_W-1:0] HK_FIRST = HK_FIRST_FULL[`SLOT_IDX_W-1:0];

   function is_valid_mode;
      input [2:0] m;
      begin
         is_valid_mode = (m == `MODE_PARALLEL) || (m == `MODE_I2C) || (m == `MODE_SPI);
      end
   endfunction

   // one filter for all seven lanes: master pins low, general pins high;
   // a one-cycle glitch on a pin never reaches the outputs
   pin_sync3 #(
      .WIDTH(`SYNC_LANES)
   ) u_sync (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .raw_in({general_pin_in, master_pin_in}),
      .level_out(pin_level)
   );

   // mode switch only between transfers, so no frame is cut mid-way
   always @* begin
      next_mode = mode_out;
      if (is_valid_mode(mode_req_in) && !transfer_busy_in) begin // see RULE13
         next_mode = mode_req_in; // see RULE1
      end
   end

   // pin steering; i2c lines are open drain, only ever driven low
   always @* begin
      next_pin_out = 4'h0;
      next_pin_oe = 4'h0;
      case (mode_out)
         `MODE_PARALLEL: begin
            next_pin_out = parallel_output_in; // see RULE2 see RULE3 see RULE4 see RULE5
            next_pin_oe = 4'hF;
         end
         `MODE_I2C: begin
            next_pin_oe[`PIN_ZERO] = master_i2c_data_drive_low_in; // see RULE2
            next_pin_oe[`PIN_ONE] = master_i2c_clock_drive_low_in; // see RULE3
            // pins two (interrupt input) and three (unused) stay released  see RULE4 see RULE5
         end
         `MODE_SPI: begin
            next_pin_out[`PIN_ZERO] = master_spi_data_out_in; // see RULE2
            next_pin_out[`PIN_ONE] = master_spi_clock_out_in; // see RULE3
            next_pin_out[`PIN_THREE] = master_spi_select_low_in; // see RULE5
            next_pin_oe[`PIN_ZERO] = 1'b1;
            next_pin_oe[`PIN_ONE] = 1'b1;
            next_pin_oe[`PIN_THREE] = 1'b1;
         end
         default: begin
            next_pin_out = 4'h0; // see RULE13
            next_pin_oe = 4'h0;
         end
      endcase
   end

   // a general pin used as sync input is not driven from the first clock edge after it is selected
   always @* begin
      next_gen_oe = general_pin_dir_in; // see RULE8
      if (sync_select_in[`SEL_HSYNC]) begin
         next_gen_oe[`GEN_ONE] = 1'b0; // see RULE9
      end
      if (sync_select_in[`SEL_VSYNC]) begin
         next_gen_oe[`GEN_TWO] = 1'b0; // see RULE9
      end
   end

   // all state resets asynchronously on reset low  see RULE10 see RULE11
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_out <= `MODE_NONE;
         master_pin_out <= 4'h0;
         master_pin_oe_out <= 4'h0;
         // line outputs idle high, as their pulled-up pins would read
         master_i2c_data_line_out <= 1'b1;
         master_i2c_clock_line_out <= 1'b1;
         master_interrupt_low_out <= 1'b1;
         master_spi_data_in_out <= 1'b0;
         general_pin_out <= 3'h0;
         general_pin_oe_out <= 3'h0;
         general_pin_rd_out <= 3'h0;
         hsync_out <= 1'b0;
         vsync_out <= 1'b0;
      end else begin
         // pins follow one cycle after mode_out, so a new mode never glitches old pins
         mode_out <= next_mode;
         master_pin_out <= next_pin_out;
         master_pin_oe_out <= next_pin_oe;
         if (mode_out == `MODE_I2C) begin
            master_i2c_data_line_out <= pin_level[`PIN_ZERO];
            master_i2c_clock_line_out <= pin_level[`PIN_ONE];
            // interrupt is level: renderer polls peripherals to find the source  see RULE6 see RULE7
            master_interrupt_low_out <= pin_level[`PIN_TWO]; // see RULE4
         end else begin
            master_i2c_data_line_out <= 1'b1;
            master_i2c_clock_line_out <= 1'b1;
            master_interrupt_low_out <= 1'b1;
         end
         if (mode_out == `MODE_SPI) begin
            master_spi_data_in_out <= pin_level[`PIN_TWO]; // see RULE4
         end else begin
            master_spi_data_in_out <= 1'b0;
         end
         general_pin_out <= general_pin_wr_in; // see RULE8
         general_pin_oe_out <= next_gen_oe;
         general_pin_rd_out <= pin_level[`LANE_GEN_BASE +: 3];
         hsync_out <= sync_select_in[`SEL_HSYNC] & pin_level[`LANE_GEN_BASE + `GEN_ONE];
         vsync_out <= sync_select_in[`SEL_VSYNC] & pin_level[`LANE_GEN_BASE + `GEN_TWO];
      end
   end

   // frame scheduler: last slots of each frame are housekeeping
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         slot_cycle <= {`SLOT_CNT_W{1'b0}};
         slot_index_out <= {`SLOT_IDX_W{1'b0}};
         frame_start_out <= 1'b0;
         slot_housekeeping_out <= 1'b0;
      end else if (!acq_enable_in) begin
         slot_cycle <= {`SLOT_CNT_W{1'b0}};
         slot_index_out <= {`SLOT_IDX_W{1'b0}};
         frame_start_out <= 1'b0;
         slot_housekeeping_out <= 1'b0;
      end else begin
         frame_start_out <= 1'b0;
         if (slot_cycle == SLOT_LAST) begin
            slot_cycle <= {`SLOT_CNT_W{1'b0}};
            if (slot_index_out == FRAME_LAST) begin
               slot_index_out <= {`SLOT_IDX_W{1'b0}}; // see RULE12
               frame_start_out <= 1'b1;
               slot_housekeeping_out <= 1'b0;
            end else begin
               // housekeeping level moves with the index, so both read as one
               slot_index_out <= slot_index_out + 1'b1;
               slot_housekeeping_out <= (slot_index_out + 1'b1) >= HK_FIRST; // see RULE12
            end
         end else begin
            slot_cycle <= slot_cycle + 1'b1;
         end
      end
   end

endmodule // master_port_pin_mux

`default_nettype wire

// file: logic/pin_sync3.v
// three-stage pin input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module pin_sync3 #(
   parameter WIDTH = 1
) (
   // clock and reset
   input wire clk_in,
   input wire nrst_in,
   // raw and filtered levels
   input wire [WIDTH-1:0] raw_in,
   output reg [WIDTH-1:0] level_out
);

   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;

   // stage1 feeds only stage2; pull-ups make idle level high
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         stage1 <= {WIDTH{1'b1}};
         stage2 <= {WIDTH{1'b1}};
         stage3 <= {WIDTH{1'b1}};
         level_out <= {WIDTH{1'b1}};
      end else begin
         stage1 <= raw_in;
         stage2 <= stage1;
         stage3 <= stage2;
         level_out <= (stage2 & stage3) | (level_out & (stage2 ^ stage3));
      end
   end

endmodule // pin_sync3

`default_nettype wire

// file: tb/haptic_peripheral_model.sv
// far-side peripheral: pull-ups, open-drain interrupt, spi data in
`timescale 1ns/1ps
`default_nettype none
module haptic_peripheral_model (
   // pin drive from the block
   input wire logic [3:0] pin_out_in,
   input wire logic [3:0] pin_oe_in,
   // peripheral behaviour
   input wire logic irq_req_in,
   input wire logic miso_in,
   // pin levels and the interrupt status the peripheral reports when asked
   output wire logic [3:0] pin_level_out,
   output wire logic irq_status_out
);
   wire logic [3:0] pulled;
   wire logic far_two;
   // released lines rest at the weak pull-up level
   assign pulled = (pin_oe_in & pin_out_in) | ~pin_oe_in;
   // interrupt pulls low; data in only while selected
   assign far_two = irq_req_in ? 1'h0 : !pulled[3] ? miso_in : 1'h1;
   assign pin_level_out = {pulled[3], pin_oe_in[2] ? pin_out_in[2] : far_two, pulled[1:0]};
   // a sharer of the interrupt line answers with this over i2c
   assign irq_status_out = irq_req_in;
endmodule // haptic_peripheral_model
`default_nettype wire

// file: tb/master_port_pin_mux_asserts.sv
// checker for the master port pin multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "master_port_regs.vh"
module master_port_pin_mux_asserts #(
   parameter SLOTS_PER_FRAME = 16,
   parameter SLOT_CYCLES = 64,
   parameter HOUSEKEEPING_SLOTS = 2
) (
   // clock, reset and mode
   input wire logic clk_in,
   input wire logic nrst_in,
   input wire logic transfer_busy_in,
   input wire logic acq_enable_in,
   input wire logic [2:0] mode_req_in,
   input wire logic [2:0] mode_out,
   // master and general pins
   input wire logic [3:0] parallel_output_in,
   input wire logic [3:0] master_pin_out,
   input wire logic [3:0] master_pin_oe_out,
   input wire logic master_i2c_data_drive_low_in,
   input wire logic master_i2c_clock_drive_low_in,
   input wire logic master_spi_data_out_in,
   input wire logic master_spi_clock_out_in,
   input wire logic master_spi_select_low_in,
   input wire logic [1:0] sync_select_in,
   input wire logic [2:0] general_pin_oe_out,
   // scheduler
   input wire logic frame_start_out
);
   int unsigned gap;
   logic seen;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!nrst_in);
   // gap only trusted between two pulses of one enabled run
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gap <= 0;
         seen <= 1'h0;
      end else if (!acq_enable_in) begin
         seen <= 1'h0;
      end else if (frame_start_out) begin
         gap <= 1;
         seen <= 1'h1;
      end else begin
         gap <= gap + 1;
      end
   end
   property p_take;
      $onehot(mode_req_in) && !transfer_busy_in |=> mode_out == $past(mode_req_in);
   endproperty
   a_take: assert property (p_take) else $error("mode not taken");
   property p_hold;
      transfer_busy_in || !$onehot(mode_req_in) |=> $stable(mode_out);
   endproperty
   a_hold: assert property (p_hold) else $error("mode changed");
   property p_par;
      mode_out == `MODE_PARALLEL |=> master_pin_oe_out == 4'hF
         && master_pin_out == $past(parallel_output_in);
   endproperty
   a_par: assert property (p_par) else $error("parallel pins wrong");
   property p_i2c;
      mode_out == `MODE_I2C |=> master_pin_out[1:0] == 2'h0 && master_pin_oe_out ==
         {2'h0, $past(master_i2c_clock_drive_low_in), $past(master_i2c_data_drive_low_in)};
   endproperty
   a_i2c: assert property (p_i2c) else $error("i2c pins wrong");
   property p_spi;
      mode_out == `MODE_SPI |=> master_pin_oe_out == 4'hB
         && master_pin_out[0] == $past(master_spi_data_out_in)
         && master_pin_out[1] == $past(master_spi_clock_out_in)
         && master_pin_out[3] == $past(master_spi_select_low_in);
   endproperty
   a_spi: assert property (p_spi) else $error("spi pins wrong");
   property p_none;
      mode_out == `MODE_NONE |=> master_pin_oe_out == 4'h0;
   endproperty
   a_none: assert property (p_none) else $error("pins driven with no mode");
   property p_sync;
      sync_select_in[0] [*2] |-> !general_pin_oe_out[1];
   endproperty
   a_sync: assert property (p_sync) else $error("sync pin driven");
   property p_vsync;
      sync_select_in[1] [*2] |-> !general_pin_oe_out[2];
   endproperty
   a_vsync: assert property (p_vsync) else $error("vsync pin driven");
   property p_frame;
      frame_start_out && seen |-> gap == SLOTS_PER_FRAME * SLOT_CYCLES;
   endproperty
   a_frame: assert property (p_frame) else $error("frame length wrong");
   c_i2c: cover property (mode_out == `MODE_I2C);
   c_spi: cover property (mode_out == `MODE_SPI);
   c_frame: cover property (frame_start_out && seen);
endmodule // master_port_pin_mux_asserts
bind master_port_pin_mux master_port_pin_mux_asserts #(.SLOTS_PER_FRAME(SLOTS_PER_FRAME),
   .SLOT_CYCLES(SLOT_CYCLES), .HOUSEKEEPING_SLOTS(HOUSEKEEPING_SLOTS)) u_chk (.clk_in,
   .nrst_in, .transfer_busy_in, .acq_enable_in, .mode_req_in, .mode_out, .parallel_output_in,
   .master_pin_out, .master_pin_oe_out, .master_i2c_data_drive_low_in,
   .master_i2c_clock_drive_low_in, .master_spi_data_out_in, .master_spi_clock_out_in,
   .master_spi_select_low_in, .sync_select_in, .general_pin_oe_out, .frame_start_out);
`default_nettype wire

// file: tb/master_port_pin_mux_tb.sv
// testbench for the master port pin multiplexer
`timescale 1ns/1ps
`default_nettype none
module master_port_pin_mux_tb;
   logic clk_in = 0, nrst_in = 0, busy = 0, acq = 0, irq = 0, miso = 0;
   logic dl = 0, cl = 0, sdo = 0, sck = 0, ssl = 1;
   logic [2:0] req = 0, dir = 0, wr = 0, gext = 3'h2;
   logic [1:0] sel = 0;
   logic [3:0] par = 0;
   wire [3:0] pout, poe, plvl;
   wire [2:0] mode, gout, goe, grd;
   wire [2:0] gin = (goe & gout) | (~goe & gext);
   wire sda, scl, irqn, sdi, hs, vs, fs, hk, irq_stat;
   wire [7:0] slot;
   int fails = 0, n_checks = 0, n;
   master_port_pin_mux #(.SLOTS_PER_FRAME(4), .SLOT_CYCLES(4), .HOUSEKEEPING_SLOTS(1))
      u_master_port_pin_mux (.clk_in, .nrst_in, .mode_req_in(req), .transfer_busy_in(busy),
      .mode_out(mode), .parallel_output_in(par), .master_i2c_data_drive_low_in(dl),
      .master_i2c_clock_drive_low_in(cl), .master_i2c_data_line_out(sda),
      .master_i2c_clock_line_out(scl), .master_interrupt_low_out(irqn),
      .master_spi_data_out_in(sdo), .master_spi_clock_out_in(sck),
      .master_spi_select_low_in(ssl), .master_spi_data_in_out(sdi), .master_pin_in(plvl),
      .master_pin_out(pout), .master_pin_oe_out(poe), .general_pin_dir_in(dir),
      .general_pin_wr_in(wr), .sync_select_in(sel), .general_pin_in(gin),
      .general_pin_out(gout), .general_pin_oe_out(goe), .general_pin_rd_out(grd),
      .hsync_out(hs), .vsync_out(vs), .acq_enable_in(acq), .frame_start_out(fs),
      .slot_index_out(slot), .slot_housekeeping_out(hk));
   haptic_peripheral_model u_haptic_peripheral_model (.pin_out_in(pout), .pin_oe_in(poe),
      .irq_req_in(irq), .miso_in(miso), .pin_level_out(plvl), .irq_status_out(irq_stat));
   initial forever #50 clk_in = ~clk_in;
   task step(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task end_sim;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // bounded wait for the next frame pulse, n returns the cycles taken
   task wfs;
      n = 0;
      do begin
         step(1);
         n++;
      end while (fs !== 1'h1 && n < 200);
      if (fs !== 1'h1) begin
         fails++;
         $display("[FAIL] %0t frame pulse timeout", $time);
         end_sim;
      end
   endtask
   task t_par;
      req = 3'h1;
      par = 4'hA;
      step(3);
      chk(mode, 3'h1);
      chk(poe, 4'hF);
      chk(pout, 4'hA);
      par = 4'h5;
      step(2);
      chk(pout, 4'h5);
      $display("t_par done");
   endtask
   task t_i2c;
      req = 3'h2;
      dl = 1;
      irq = 1;
      step(7);
      chk(poe, 4'h1);
      chk(pout[1:0], 2'h0);
      chk(sda, 1'h0);
      chk(scl, 1'h1);
      chk(irqn, 1'h0);
      chk(irqn, !irq_stat);
      dl = 0;
      cl = 1;
      irq = 0;
      step(7);
      chk(poe, 4'h2);
      chk(scl, 1'h0);
      chk(sda, 1'h1);
      chk(irqn, 1'h1);
      chk(irqn, !irq_stat);
      $display("t_i2c done");
   endtask
   task t_spi;
      req = 3'h4;
      cl = 0;
      sdo = 1;
      ssl = 0;
      step(7);
      chk(poe, 4'hB);
      chk(pout & 4'hB, 4'h1);
      chk(sdi, 1'h0);
      sdo = 0;
      sck = 1;
      miso = 1;
      step(7);
      chk(pout & 4'hB, 4'h2);
      chk(sdi, 1'h1);
      ssl = 1;
      miso = 0;
      step(7);
      chk(pout & 4'hB, 4'hA);
      chk(sdi, 1'h1);
      chk(irqn, 1'h1);
      $display("t_spi done");
   endtask
   task t_busy;
      busy = 1;
      req = 3'h1;
      step(3);
      chk(mode, 3'h4);
      busy = 0;
      req = 3'h3;
      step(3);
      chk(mode, 3'h4);
      req = 3'h4;
      $display("t_busy done");
   endtask
   task t_gen;
      dir = 3'h7;
      wr = 3'h5;
      sel = 2'h1;
      step(7);
      chk(goe, 3'h5);
      chk(gout, 3'h5);
      chk(grd, 3'h7);
      chk(hs, 1'h1);
      sel = 2'h2;
      gext = 3'h4;
      step(7);
      chk(goe, 3'h3);
      chk(grd, 3'h5);
      chk(vs, 1'h1);
      chk(hs, 1'h0);
      $display("t_gen done");
   endtask
   task t_sched;
      acq = 1;
      wfs;
      wfs;
      chk(n[7:0], 8'h10);
      chk(slot, 8'h0);
      chk(hk, 1'h0);
      step(12);
      chk(slot, 8'h3);
      chk(hk, 1'h1);
      wfs;
      chk(n[7:0], 8'h4);
      $display("t_sched done");
   endtask
   task t_rst;
      nrst_in = 0;
      #10;
      chk(poe, 4'h0);
      chk(mode, 3'h0);
      chk(fs, 1'h0);
      chk(sdi, 1'h0);
      chk(gout, 3'h0);
      step(2);
      nrst_in = 1;
      step(3);
      chk(mode, 3'h4);
      chk(poe, 4'hB);
      $display("t_rst done");
   endtask
   initial begin
      step(10);
      nrst_in = 1;
      t_par;
      t_i2c;
      t_spi;
      t_busy;
      t_gen;
      t_sched;
      t_rst;
      end_sim;
   end
endmodule // master_port_pin_mux_tb
`default_nettype wire
